// [core/ncq_pkg.sv]
/*
 * Constants for the network control-queue command block: command codes,
 * acknowledge codes, feature bit positions, register offsets, header codes.
 * Assumes one synchronous clock domain and a plain register port.
 */
package ncq_pkg;
   // What this block does
   // - without transmit checksum feature, header flags are zero, partial packets dropped
   // - segmentation kinds are reported only when their guest feature is negotiated
   // - ECN segmented TCP needs guest ECN; when delivered its ECN flag is set
   // - buffer is class, command, payload, then acknowledge written by device
   // - acknowledge is 0 on success and 1 on error
   // - receive-mode commands need the receive-control feature; filtering is best effort
   // - receive-mode class 0: command 0 promiscuous, command 1 all-multicast
   // - receive-mode payload is one byte: 0 off, 1 on
   // - MAC class 1: command 0 loads table, command 1 sets default address
   // - table payload: count, unicast addresses, count, multicast addresses; zero allowed
   // - filter table is empty after reset
   // - new table is in place before the table command is consumed
   // - set-address replaces default; config address updated first when feature negotiated
   // - drop packets matching neither default address, broadcast nor table
   // - too many addresses falls back to promiscuous or all-multicast
   // - counts and VLAN id are little-endian, or guest order in legacy mode
   // - config address word writes reach the default address after the high word
   // - VLAN class 2: command 0 adds, 1 deletes; 16-bit little-endian id
   // - device may raise the announce status bit when announce is negotiated
   // - announce acknowledge clears the announce bit before buffer is used, unless a new announce is raised in that cycle
   localparam int          NENT        = 8;
   localparam logic [7:0]  CLS_RX      = 8'h00;
   localparam logic [7:0]  CLS_MAC     = 8'h01;
   localparam logic [7:0]  CLS_VLAN    = 8'h02;
   localparam logic [7:0]  CLS_ANN     = 8'h03;
   localparam logic [7:0]  RX_PROMISC  = 8'h00;
   localparam logic [7:0]  RX_ALLMULTI = 8'h01;
   localparam logic [7:0]  MAC_TABLE   = 8'h00;
   localparam logic [7:0]  MAC_ADDR    = 8'h01;
   localparam logic [7:0]  VLAN_ADD    = 8'h00;
   localparam logic [7:0]  VLAN_DEL    = 8'h01;
   localparam logic [7:0]  ANN_ACK     = 8'h00;
   localparam logic [7:0]  ACK_OK      = 8'h00;
   localparam logic [7:0]  ACK_ERR     = 8'h01;
   localparam int          F_CSUM      = 0;
   localparam int          F_MAC       = 5;
   localparam int          F_TSO4      = 7;
   localparam int          F_TSO6      = 8;
   localparam int          F_ECN       = 9;
   localparam int          F_UFO       = 10;
   localparam int          F_CTRL_VQ   = 17;
   localparam int          F_CTRL_RX   = 18;
   localparam int          F_VLAN      = 19;
   localparam int          F_ANN       = 21;
   localparam logic [6:0]  GSO_NONE    = 7'h00;
   localparam logic [6:0]  GSO_TCPV4   = 7'h01;
   localparam logic [6:0]  GSO_UDP     = 7'h03;
   localparam logic [6:0]  GSO_TCPV6   = 7'h04;
   localparam logic [7:0]  HDR_CSUM    = 8'h01;
   localparam logic [15:0] LEN_MODE    = 16'h0001;
   localparam logic [15:0] LEN_VID     = 16'h0002;
   localparam logic [15:0] LEN_MAC     = 16'h0006;
   localparam logic [2:0]  CNT_LAST    = 3'h3;
   localparam logic [2:0]  MAC_LAST    = 3'h5;
   localparam logic [2:0]  PH_UCNT     = 3'h0;
   localparam logic [2:0]  PH_END      = 3'h4;
   localparam logic [2:0]  PH_BAD      = 3'h5;
   localparam logic [7:0]  REG_FEAT    = 8'h00;
   localparam logic [7:0]  REG_CTRL    = 8'h04;
   localparam logic [7:0]  REG_STATUS  = 8'h08;
   localparam logic [7:0]  REG_MAC_LO  = 8'h0c;
   localparam logic [7:0]  REG_MAC_HI  = 8'h10;
   localparam logic [7:0]  REG_DEF_LO  = 8'h14;
   localparam logic [7:0]  REG_DEF_HI  = 8'h18;
   localparam int          CTRL_ANN    = 0;
   localparam int          CTRL_LEG    = 1;
   localparam logic [31:0] FEAT_RST    = 32'h0000_0000;
   localparam logic [47:0] MAC_RST     = 48'h0000_0000_0000;
   localparam logic [47:0] MAC_BCAST   = 48'hffff_ffff_ffff;
   localparam logic [11:0] VID_MAX     = 12'hfff;

   typedef enum logic [2:0] {
      S_CLASS = 3'b000,
      S_CMD   = 3'b001,
      S_DATA  = 3'b011,
      S_EXEC  = 3'b010,
      S_DONE  = 3'b110
   } ncq_state_t;
endpackage : ncq_pkg

// [core/ncq_ctrl.sv]
/*
 * Control-queue command executor with receive filter and receive header
 * sanitiser. Assumes command bytes come from same-clock queue logic and
 * software reaches registers over a plain strobe port.
 */
`timescale 1ns/1ps
module ncq_ctrl
   import ncq_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // command byte stream
   input  wire logic        cmd_valid_i,
   input  wire logic [7:0]  cmd_byte_i,
   input  wire logic        cmd_end_i,
   output logic             cmd_ready_o,
   output logic             cmd_used_o,
   output logic      [7:0]  ack_code_o,
   // receive address filter
   input  wire logic        rx_mac_valid_i,
   input  wire logic [47:0] rx_mac_i,
   input  wire logic        rx_tagged_i,
   input  wire logic [11:0] rx_vid_i,
   output logic             rx_res_valid_o,
   output logic             rx_accept_o,
   // receive header
   input  wire logic        hdr_valid_i,
   input  wire logic        hdr_csum_part_i,
   input  wire logic [7:0]  hdr_gso_i,
   output logic             hdr_valid_o,
   output logic             hdr_drop_o,
   output logic      [7:0]  hdr_flags_o,
   output logic      [7:0]  hdr_gso_o
);

   typedef struct packed {
      ncq_state_t                st;
      logic                      bad;
      logic [7:0]                cls;
      logic [7:0]                cmd;
      logic [15:0]               plen;
      logic [47:0]               pbuf;
      logic [2:0]                ph;
      logic [2:0]                bi;
      logic [31:0]               cnt;
      logic [3:0]                n;
      logic                      uov;
      logic                      mov;
      logic [NENT-1:0][47:0]     shd;
      logic [NENT-1:0]           shv;
      logic [NENT-1:0][47:0]     tab;
      logic [NENT-1:0]           tv;
      logic                      tuov;
      logic                      tmov;
      logic [31:0]               feat;
      logic                      leg;
      logic                      promisc;
      logic                      allmulti;
      logic                      ann;
      logic [47:0]               cfg_mac;
      logic [47:0]               def_mac;
      logic [4095:0]             vlan;
      logic                      rdy;
      logic                      used;
      logic [7:0]                ack;
      logic [31:0]               rdata;
      logic                      rx_v;
      logic                      rx_acc;
      logic                      hv;
      logic                      hdrop;
      logic [7:0]                hflags;
      logic [7:0]                hgso;
   } ncq_st_t;

   ncq_st_t           s_q;
   ncq_st_t           s_d;
   logic [NENT-1:0]   hit;
   logic              ok_c;
   logic [11:0]       vid_c;
   logic              ann_set;

   // one comparator per table entry
   genvar gi;
   generate
      for (gi = 0; gi < NENT; gi++) begin : g_hit
         assign hit[gi] = s_q.tv[gi] && (s_q.tab[gi] == rx_mac_i);
      end
   endgenerate

   // little-endian id, guest order in legacy mode
   assign vid_c = s_q.leg ? s_q.pbuf[11:0]
                          : {s_q.pbuf[3:0], s_q.pbuf[15:8]};

   assign ann_set = reg_wr_i && (reg_addr_i == REG_CTRL)
                    && reg_wdata_i[CTRL_ANN] && s_q.feat[F_ANN];

   // command legality, judged once the whole buffer is in
   always_comb begin
      ok_c = 1'b0;
      if (!s_q.bad && s_q.feat[F_CTRL_VQ]) begin
         case (s_q.cls)
            CLS_RX: ok_c = s_q.feat[F_CTRL_RX]
                           && (s_q.cmd <= RX_ALLMULTI)
                           && (s_q.plen == LEN_MODE)
                           && (s_q.pbuf[7:1] == 7'h00);
            CLS_MAC: ok_c = s_q.feat[F_CTRL_RX]
                            && (((s_q.cmd == MAC_TABLE)
                                 && (s_q.ph == PH_END))
                                || ((s_q.cmd == MAC_ADDR)
                                    && (s_q.plen == LEN_MAC)));
            CLS_VLAN: ok_c = s_q.feat[F_VLAN]
                             && (s_q.cmd <= VLAN_DEL)
                             && (s_q.plen == LEN_VID)
                             && ((s_q.leg ? s_q.pbuf[15:12]
                                          : s_q.pbuf[7:4]) == 4'h0);
            CLS_ANN: ok_c = s_q.feat[F_ANN] && (s_q.cmd == ANN_ACK)
                            && (s_q.plen == 16'h0000);
            default: ok_c = 1'b0;
         endcase
      end
   end

   always_comb begin
      logic [31:0] cv;
      logic [47:0] mac;
      logic        mc;
      logic        vok;
      logic [6:0]  kind;
      cv   = 32'h0;
      mac  = 48'h0;
      mc   = 1'b0;
      vok  = 1'b0;
      kind = 7'h00;
      s_d      = s_q;
      s_d.used = 1'b0;
      s_d.rdata = 32'h0;

      // command buffer walk: class, command, payload, then answer
      case (s_q.st)
         S_CLASS: begin
            if (cmd_valid_i && s_q.rdy) begin
               s_d.cls  = cmd_byte_i;
               s_d.bad  = cmd_end_i;
               s_d.plen = 16'h0000;
               s_d.ph   = PH_UCNT;
               s_d.bi   = 3'h0;
               s_d.cnt  = 32'h0;
               s_d.n    = 4'h0;
               s_d.shv  = '0;
               s_d.uov  = 1'b0;
               s_d.mov  = 1'b0;
               s_d.st   = cmd_end_i ? S_EXEC : S_CMD;
            end
         end
         S_CMD: begin
            if (cmd_valid_i) begin
               s_d.cmd = cmd_byte_i;
               s_d.st  = cmd_end_i ? S_EXEC : S_DATA;
            end
         end
         S_DATA: begin
            if (cmd_valid_i) begin
               s_d.pbuf = {s_q.pbuf[39:0], cmd_byte_i};
               if (s_q.plen != 16'hffff)
                  s_d.plen = 16'(s_q.plen + 16'h0001);
               // table payload: count, addresses, count, addresses
               case (s_q.ph)
                  3'h0, 3'h2: begin
                     cv = s_q.leg ? {s_q.cnt[23:0], cmd_byte_i}
                                  : {cmd_byte_i, s_q.cnt[31:8]};
                     s_d.cnt = cv;
                     s_d.bi  = 3'(s_q.bi + 3'h1);
                     if (s_q.bi == CNT_LAST) begin
                        s_d.bi = 3'h0;
                        s_d.ph = (cv == 32'h0) ? 3'(s_q.ph + 3'h2)
                                               : 3'(s_q.ph + 3'h1);
                     end
                  end
                  3'h1, 3'h3: begin
                     s_d.bi = 3'(s_q.bi + 3'h1);
                     if (s_q.bi == MAC_LAST) begin
                        s_d.bi = 3'h0;
                        mac = {s_q.pbuf[39:0], cmd_byte_i};
                        if (s_q.n < 4'(NENT)) begin
                           s_d.shd[s_q.n[2:0]] = mac;
                           s_d.shv[s_q.n[2:0]] = 1'b1;
                           s_d.n = 4'(s_q.n + 4'h1);
                        end else if (s_q.ph == 3'h1) begin
                           s_d.uov = 1'b1;
                        end else begin
                           s_d.mov = 1'b1;
                        end
                        s_d.cnt = s_q.cnt - 32'h1;
                        if (s_q.cnt == 32'h1)
                           s_d.ph = 3'(s_q.ph + 3'h1);
                     end
                  end
                  default: s_d.ph = PH_BAD;
               endcase
               if (cmd_end_i)
                  s_d.st = S_EXEC;
            end
         end
         S_EXEC: begin
            // state changes land here, a cycle before the buffer is used
            s_d.ack = ok_c ? ACK_OK : ACK_ERR;
            if (ok_c) begin
               case (s_q.cls)
                  CLS_RX: begin
                     if (s_q.cmd == RX_PROMISC)
                        s_d.promisc = s_q.pbuf[0];
                     else
                        s_d.allmulti = s_q.pbuf[0];
                  end
                  CLS_MAC: begin
                     if (s_q.cmd == MAC_TABLE) begin
                        s_d.tab  = s_q.shd;
                        s_d.tv   = s_q.shv;
                        s_d.tuov = s_q.uov;
                        s_d.tmov = s_q.mov;
                     end else begin
                        s_d.def_mac = s_q.pbuf;
                        if (s_q.feat[F_MAC])
                           s_d.cfg_mac = s_q.pbuf;
                     end
                  end
                  CLS_VLAN: s_d.vlan[vid_c] = (s_q.cmd == VLAN_ADD);
                  CLS_ANN: s_d.ann = 1'b0;
                  default: s_d.ann = s_q.ann;
               endcase
            end
            s_d.st = S_DONE;
         end
         S_DONE: begin
            s_d.used = 1'b1;
            s_d.st   = S_CLASS;
         end
         default: s_d.st = S_CLASS;
      endcase
      s_d.rdy = (s_d.st == S_CLASS) || (s_d.st == S_CMD)
                || (s_d.st == S_DATA);

      // register writes; a raised announce beats a same-cycle clear
      if (reg_wr_i) begin
         case (reg_addr_i)
            REG_FEAT: s_d.feat = reg_wdata_i;
            REG_CTRL: s_d.leg  = reg_wdata_i[CTRL_LEG];
            REG_MAC_LO: s_d.cfg_mac[47:16] = reg_wdata_i;
            REG_MAC_HI: begin
               s_d.cfg_mac[15:0] = reg_wdata_i[15:0];
               s_d.def_mac = {s_d.cfg_mac[47:16], reg_wdata_i[15:0]};
            end
            default: s_d.leg = s_d.leg;
         endcase
      end
      if (ann_set)
         s_d.ann = 1'b1;
      if (reg_rd_i) begin
         case (reg_addr_i)
            REG_FEAT: s_d.rdata = s_q.feat;
            REG_CTRL: s_d.rdata = {30'h0, s_q.leg, 1'b0};
            REG_STATUS: s_d.rdata = {24'h0, s_q.n[3:0], s_q.tmov, s_q.tuov,
                                     s_q.ann, s_q.promisc}
                                    | {30'h0, s_q.allmulti, 1'b0} << 4;
            REG_MAC_LO: s_d.rdata = s_q.cfg_mac[47:16];
            REG_MAC_HI: s_d.rdata = {16'h0, s_q.cfg_mac[15:0]};
            REG_DEF_LO: s_d.rdata = s_q.def_mac[47:16];
            REG_DEF_HI: s_d.rdata = {16'h0, s_q.def_mac[15:0]};
            default: s_d.rdata = 32'h0;
         endcase
      end

      // destination filter, overflow falls back to wider reception
      mc  = rx_mac_i[40];
      vok = !s_q.feat[F_VLAN] || !rx_tagged_i || s_q.vlan[rx_vid_i];
      s_d.rx_v   = rx_mac_valid_i;
      s_d.rx_acc = rx_mac_valid_i && vok
                   && (s_q.promisc || s_q.tuov
                       || (rx_mac_i == s_q.def_mac) || (|hit)
                       || (rx_mac_i == MAC_BCAST)
                       || (mc && (s_q.allmulti || s_q.tmov)));

      // receive header sanitising
      kind = hdr_gso_i[6:0];
      s_d.hv    = hdr_valid_i;
      s_d.hdrop = hdr_valid_i
         && ((hdr_csum_part_i && !s_q.feat[F_CSUM])
             || ((kind == GSO_TCPV4) && !s_q.feat[F_TSO4])
             || ((kind == GSO_TCPV6) && !s_q.feat[F_TSO6])
             || ((kind == GSO_UDP) && !s_q.feat[F_UFO])
             || ((kind != GSO_NONE) && (kind != GSO_TCPV4)
                 && (kind != GSO_TCPV6) && (kind != GSO_UDP))
             || (hdr_gso_i[7] && !s_q.feat[F_ECN]));
      s_d.hflags = (hdr_valid_i && s_q.feat[F_CSUM] && hdr_csum_part_i)
                   ? HDR_CSUM : 8'h00;
      s_d.hgso   = s_d.hdrop ? 8'h00 : hdr_gso_i;
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_q         <= '0;
         s_q.feat    <= FEAT_RST;
         s_q.cfg_mac <= MAC_RST;
         s_q.def_mac <= MAC_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o    = s_q.rdata;
   assign cmd_ready_o    = s_q.rdy;
   assign cmd_used_o     = s_q.used;
   assign ack_code_o     = s_q.ack;
   assign rx_res_valid_o = s_q.rx_v;
   assign rx_accept_o    = s_q.rx_acc;
   assign hdr_valid_o    = s_q.hv;
   assign hdr_drop_o     = s_q.hdrop;
   assign hdr_flags_o    = s_q.hflags;
   assign hdr_gso_o      = s_q.hgso;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   property p_flags_zero;
      hdr_valid_o && !$past(s_q.feat[F_CSUM]) |-> hdr_flags_o == 8'h00;
   endproperty
   a_flags_zero: assert property (p_flags_zero)
      else $error("flags set without checksum feature");

   property p_gso_kind;
      $past(hdr_valid_i && hdr_gso_i[6:0] == GSO_TCPV4 && !s_q.feat[F_TSO4])
      |-> hdr_drop_o && hdr_gso_o == 8'h00;
   endproperty
   a_gso_kind: assert property (p_gso_kind)
      else $error("unnegotiated tcpv4 kind passed");

   property p_ecn;
      hdr_valid_o && !hdr_drop_o && $past(hdr_gso_i[7]) |-> hdr_gso_o[7];
   endproperty
   a_ecn: assert property (p_ecn)
      else $error("ecn flag lost");

   property p_err_keeps;
      s_q.st == S_EXEC && !ok_c |=> $stable(s_q.tv) && $stable(s_q.promisc)
         ##1 cmd_used_o && ack_code_o == ACK_ERR;
   endproperty
   a_err_keeps: assert property (p_err_keeps)
      else $error("bad command changed state or not refused");

   property p_table_first;
      s_q.st == S_EXEC && ok_c && s_q.cls == CLS_MAC && s_q.cmd == MAC_TABLE
      |=> s_q.tv == $past(s_q.shv) && !cmd_used_o ##1 cmd_used_o;
   endproperty
   a_table_first: assert property (p_table_first)
      else $error("table not loaded before use");

   property p_ann_clear;
      s_q.st == S_EXEC && ok_c && s_q.cls == CLS_ANN && !ann_set
      |=> !s_q.ann && !cmd_used_o ##1 cmd_used_o && ack_code_o == ACK_OK;
   endproperty
   a_ann_clear: assert property (p_ann_clear)
      else $error("announce not cleared before use");

   property p_mode;
      s_q.st == S_EXEC && ok_c && s_q.cls == CLS_RX && s_q.cmd == RX_PROMISC
      |=> s_q.promisc == $past(s_q.pbuf[0]);
   endproperty
   a_mode: assert property (p_mode)
      else $error("promiscuous mode not applied");

   property p_rx_needs_feat;
      s_q.st == S_EXEC && s_q.cls == CLS_RX && !s_q.feat[F_CTRL_RX]
      |=> ack_code_o == ACK_ERR;
   endproperty
   a_rx_needs_feat: assert property (p_rx_needs_feat)
      else $error("receive command accepted without feature");

   property p_reset_empty;
      $past(reset_i) |-> s_q.tv == '0;
   endproperty
   a_reset_empty: assert property (p_reset_empty)
      else $error("table not empty after reset");
endmodule : ncq_ctrl

// [testbench/ncq_drv_model.sv]
/* Driver-side model that feeds control command buffers byte by byte.
   Assumes registered ready and used outputs on the same clock. */
`timescale 1ns/1ps
module ncq_drv_model (
   // clock
   input  wire logic       core_clk_i,
   // command stream from the device
   input  wire logic       cmd_ready_i,
   input  wire logic       cmd_used_i,
   input  wire logic [7:0] ack_code_i,
   // command stream to the device
   output logic            cmd_valid_o,
   output logic      [7:0] cmd_byte_o,
   output logic            cmd_end_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_byte_o  = 8'h00;
      cmd_end_o   = 1'b0;
   end

   // class, command, payload; the device answers with the ack byte
   task automatic send(input logic [7:0] q[$], output logic [7:0] ack);
      int n;
      for (int i = 0; i < q.size(); i++) begin
         cmd_valid_o <= 1'b1;
         cmd_byte_o  <= q[i];
         cmd_end_o   <= (i == q.size() - 1);
         n = 0;
         do begin
            @(posedge core_clk_i);
            n++;
         end while (!cmd_ready_i && n < 50);
      end
      // released line shows the inverse, not the last byte
      cmd_valid_o <= 1'b0;
      cmd_end_o   <= 1'b0;
      cmd_byte_o  <= ~cmd_byte_o;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (cmd_used_i !== 1'b1 && n < 20);
      ack = cmd_used_i ? ack_code_i : 8'hff;
   endtask : send
endmodule : ncq_drv_model

// [testbench/ncq_ctrl_bench.sv]
/* Bench for the control-queue block: registers, commands, filter, headers.
   Assumes the driver model is compiled before it. */
`timescale 1ns/1ps
module ncq_ctrl_bench
   import ncq_pkg::*;
;
   localparam logic [47:0] MA = 48'h02_11_22_33_44_55;
   localparam logic [47:0] MM = 48'h01_00_5e_00_00_01;
   localparam logic [47:0] MC = 48'h02_ca_fe_00_00_01;
   localparam logic [31:0] FB = (32'h1 << F_CTRL_VQ) | (32'h1 << F_CTRL_RX)
                              | (32'h1 << F_MAC) | (32'h1 << F_CSUM)
                              | (32'h1 << F_TSO4);
   localparam logic [31:0] FV = FB | (32'h1 << F_VLAN) | (32'h1 << F_ANN);
   logic core_clk_i = 1'b0, reset_i = 1'b1;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, cmd_valid_i, cmd_end_i;
   logic [7:0] reg_addr_i = 8'h00, cmd_byte_i, ack_code_o, hdr_flags_o;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
   logic cmd_ready_o, cmd_used_o, rx_res_valid_o, rx_accept_o;
   logic rx_mac_valid_i = 1'b0, rx_tagged_i = 1'b0, hdr_valid_i = 1'b0;
   logic [47:0] rx_mac_i = 48'h0;
   logic [11:0] rx_vid_i = 12'h000;
   logic hdr_csum_part_i = 1'b0, hdr_valid_o, hdr_drop_o;
   logic [7:0] hdr_gso_i = 8'h00, hdr_gso_o;
   int err_count = 0, checks = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   ncq_ctrl ncq_ctrl_inst (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cmd_valid_i, .cmd_byte_i,
      .cmd_end_i, .cmd_ready_o, .cmd_used_o, .ack_code_o, .rx_mac_valid_i,
      .rx_mac_i, .rx_tagged_i, .rx_vid_i, .rx_res_valid_o, .rx_accept_o,
      .hdr_valid_i, .hdr_csum_part_i, .hdr_gso_i, .hdr_valid_o, .hdr_drop_o,
      .hdr_flags_o, .hdr_gso_o);
   ncq_drv_model ncq_drv_model_inst (.core_clk_i, .cmd_ready_i(cmd_ready_o),
      .cmd_used_i(cmd_used_o), .ack_code_i(ack_code_o),
      .cmd_valid_o(cmd_valid_i), .cmd_byte_o(cmd_byte_i),
      .cmd_end_o(cmd_end_i));

   task automatic chk(input string nm, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= v;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      v = reg_rdata_o;
   endtask : rd

   task automatic cmd(input logic [7:0] q[$], input logic [7:0] e);
      logic [7:0] a;
      ncq_drv_model_inst.send(q, a);
      chk("ack", {24'h0, e}, {24'h0, a});
   endtask : cmd

   task automatic rx(input logic [47:0] m, input logic t,
                     input logic [11:0] v, input logic e);
      rx_mac_valid_i <= 1'b1;
      rx_mac_i       <= m;
      rx_tagged_i    <= t;
      rx_vid_i       <= v;
      @(posedge core_clk_i);
      rx_mac_valid_i <= 1'b0;
      @(posedge core_clk_i);
      chk("accept", {30'h0, 1'b1, e}, {30'h0, rx_res_valid_o, rx_accept_o});
   endtask : rx

   task automatic hdr(input logic p, input logic [7:0] g,
                      input logic [16:0] e);
      hdr_valid_i     <= 1'b1;
      hdr_csum_part_i <= p;
      hdr_gso_i       <= g;
      @(posedge core_clk_i);
      hdr_valid_i <= 1'b0;
      @(posedge core_clk_i);
      chk("hdr", {14'h0, 1'b1, e},
          {14'h0, hdr_valid_o, hdr_drop_o, hdr_flags_o, hdr_gso_o});
   endtask : hdr

   task automatic end_sim;
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge core_clk_i);
      err_count++;
      end_sim();
   end

   initial begin
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      rd(REG_STATUS, d);
      chk("status", 32'h0, d);
      rd(8'h1c, d);
      chk("unmapped", 32'h0, d);
      rx(MA, 1'b0, 12'h000, 1'b0);
      rx(MAC_BCAST, 1'b0, 12'h000, 1'b1);
      cmd('{CLS_RX, RX_PROMISC, 8'h01}, ACK_ERR);
      rx(MA, 1'b0, 12'h000, 1'b0);
      wr(REG_FEAT, FB);
      rd(REG_FEAT, d);
      chk("feat", FB, d);
      cmd('{CLS_RX, RX_PROMISC, 8'h01}, ACK_OK);
      rd(REG_STATUS, d);
      chk("promisc", 32'h1, d & 32'h1);
      rx(MA, 1'b0, 12'h000, 1'b1);
      cmd('{CLS_RX, RX_PROMISC, 8'h00}, ACK_OK);
      rx(MA, 1'b0, 12'h000, 1'b0);
      cmd('{CLS_RX, RX_ALLMULTI, 8'h01}, ACK_OK);
      rx(MM, 1'b0, 12'h000, 1'b1);
      cmd('{CLS_RX, RX_ALLMULTI, 8'h00}, ACK_OK);
      rx(MM, 1'b0, 12'h000, 1'b0);
      cmd('{CLS_RX, RX_ALLMULTI, 8'h02}, ACK_ERR);
      cmd('{8'h07, 8'h00}, ACK_ERR);
      cmd('{CLS_MAC, MAC_TABLE, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h11,
            8'h22, 8'h33, 8'h44, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00},
          ACK_OK);
      rx(MA, 1'b0, 12'h000, 1'b1);
      cmd('{CLS_MAC, MAC_TABLE, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00}, ACK_ERR);
      rx(MA, 1'b0, 12'h000, 1'b1);
      cmd('{CLS_MAC, MAC_ADDR, 8'h02, 8'haa, 8'hbb, 8'hcc, 8'hdd, 8'hee},
          ACK_OK);
      rd(REG_MAC_LO, d);
      chk("cfg_mac", 32'h02aabbcc, d);
      rx(48'h02aabbccddee, 1'b0, 12'h000, 1'b1);
      wr(REG_MAC_LO, 32'h02cafe00);
      rd(REG_DEF_LO, d);
      chk("def_lo", 32'h02aabbcc, d);
      wr(REG_MAC_HI, 32'h00000001);
      rd(REG_DEF_LO, d);
      chk("def_lo", 32'h02cafe00, d);
      wr(REG_FEAT, FV);
      rx(MC, 1'b1, 12'h123, 1'b0);
      cmd('{CLS_VLAN, VLAN_ADD, 8'h23, 8'h01}, ACK_OK);
      rx(MC, 1'b1, 12'h123, 1'b1);
      rx(MC, 1'b1, 12'h231, 1'b0);
      cmd('{CLS_VLAN, VLAN_DEL, 8'h23, 8'h01}, ACK_OK);
      rx(MC, 1'b1, 12'h123, 1'b0);
      wr(REG_CTRL, 32'h2);
      cmd('{CLS_VLAN, VLAN_ADD, 8'h04, 8'h56}, ACK_OK);
      rx(MC, 1'b1, 12'h456, 1'b1);
      wr(REG_CTRL, 32'h1);
      rd(REG_STATUS, d);
      chk("announce", 32'h2, d & 32'h2);
      cmd('{CLS_ANN, ANN_ACK}, ACK_OK);
      rd(REG_STATUS, d);
      chk("announce", 32'h0, d & 32'h2);
      hdr(1'b1, 8'h00, {1'b0, HDR_CSUM, 8'h00});
      hdr(1'b0, 8'h01, {1'b0, 8'h00, 8'h01});
      hdr(1'b0, 8'h04, {1'b1, 8'h00, 8'h00});
      hdr(1'b0, 8'h03, {1'b1, 8'h00, 8'h00});
      hdr(1'b0, 8'h81, {1'b1, 8'h00, 8'h00});
      wr(REG_FEAT, (FV & ~(32'h1 << F_CSUM)) | (32'h1 << F_ECN));
      hdr(1'b1, 8'h00, {1'b1, 8'h00, 8'h00});
      hdr(1'b0, 8'h81, {1'b0, 8'h00, 8'h81});
      wr(REG_FEAT, FV & ~(32'h1 << F_TSO4));
      hdr(1'b0, 8'h01, {1'b1, 8'h00, 8'h00});
      end_sim();
   end
endmodule : ncq_ctrl_bench
